/* tsif_cpu_model.sv */
// Processor-side model: register bus master and interrupt service routine
module tsif_cpu_model
    import tsif_pkg::*;
(
    input wire logic mclk_i,
    input wire logic [DATA_W-1:0] rdata_i,
    input wire logic irq_i,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Idle bus
    // ************************************************************
    // Strobes low from time zero so nothing is taken during reset
    initial begin
        addr_o = 16'h0000;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // ************************************************************
    // Bus cycles
    // ************************************************************
    // One-cycle write; afterwards address and data are inverted so stale values never help
    task automatic bus_write(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge mclk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask

    // One-cycle read; data taken in the single cycle after the strobe
    task automatic bus_read(input logic [15:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge mclk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask

    // ************************************************************
    // Interrupt service
    // ************************************************************
    // Clears only the done flag, leaving other pending sources alone
    task automatic service_conv_done(output logic [15:0] seen);
        bus_read(FLAGS_OFF, seen);
        bus_write(FLAGS_OFF, seen & ~16'h0001);
    endtask
endmodule

/* tsif_ctrl.sv */
// Interrupt enable and flag registers of the touch measurement module
module tsif_ctrl
    import tsif_pkg::*;
#(
    parameter int unsigned NUM_CH = 16  // Receive channels
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic max_count_evt_i,
    input wire logic conv_counter_evt_i,
    input wire logic module_timer_evt_i,
    input wire logic detection_evt_i,
    input wire logic [NUM_CH-1:0] receive_channel_en_i,
    input wire logic [NUM_CH-1:0] receive_channel_done_i,
    input wire logic conversion_in_progress_i,
    input wire logic module_power_on_i,
    output logic [1:0] conv_state_o,
    output logic irq_o
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [DATA_W-1:0] touch_irq_enable_r;  // Enable register
    logic [DATA_W-1:0] rdata_r;             // Registered read data
    logic [NUM_SRC-1:0] flags;              // Flag cells, packed
    logic [NUM_SRC-1:0] hw_set;             // Hardware set pulses
    logic [NUM_SRC-1:0] wr_bits;            // Write data gathered per source
    logic [DATA_W-1:0] touch_irq_flags;     // Flags at register positions
    logic flags_wr;                         // Write to flag register
    logic enable_wr;                        // Write to enable register
    logic cip_r;                            // Previous in-progress level
    logic launch;                           // New conversion started
    logic all_done;                         // Every enabled channel ready
    logic conv_done_set;                    // Set pulse for done flag
    tsif_conv_t conv_r;                     // Conversion tracker
    tsif_conv_t conv_nxt;                   // Next tracker state

    // Address match, used for reads and writes alike
    function automatic logic tsif_hit(input logic [ADDR_W-1:0] a,
                                      input logic [15:0] off);
        return a == off;
    endfunction

    // ************************************************************
    // Write decode
    // ************************************************************
    always_comb begin
        enable_wr = 1'b0;
        flags_wr = 1'b0;
        if (wr_i && tsif_hit(addr_i, ENABLE_OFF)) begin
            enable_wr = 1'b1;
        end else if (wr_i && tsif_hit(addr_i, FLAGS_OFF)) begin
            flags_wr = 1'b1;
        end
    end

    // ************************************************************
    // Enable register
    // ************************************************************
    // Only the five enable bits are stored, the rest stay zero
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            touch_irq_enable_r <= ENABLE_RST;
        end else if (enable_wr) begin
            // Reserved bits masked away on the way in
            touch_irq_enable_r <= wdata_i & IMPL_MASK;
        end
    end

    // ************************************************************
    // Conversion tracking
    // ************************************************************
    // Edge of the in-progress level marks a launch
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cip_r <= 1'b0;
        end else begin
            cip_r <= conversion_in_progress_i;
        end
    end

    assign launch = conversion_in_progress_i & ~cip_r;

    // A channel that is not enabled counts as ready; no channel
    // enabled never completes, so an empty scan raises nothing
    assign all_done = (&(receive_channel_done_i | ~receive_channel_en_i))
                      & (|receive_channel_en_i);

    // Tracker keeps the flag from being set twice per conversion
    always_comb begin
        conv_nxt = conv_r;
        case (conv_r)
            CONV_IDLE: begin
                if (module_power_on_i && launch) begin
                    conv_nxt = CONV_BUSY;
                end
            end
            CONV_BUSY: begin
                if (!module_power_on_i) begin
                    conv_nxt = CONV_IDLE;
                end else if (all_done) begin
                    conv_nxt = CONV_DONE;
                end
            end
            CONV_DONE: begin
                if (!module_power_on_i) begin
                    conv_nxt = CONV_IDLE;
                end else if (launch) begin
                    conv_nxt = CONV_BUSY;
                end
            end
            default: begin
                conv_nxt = CONV_IDLE;
            end
        endcase
    end

    // Tracker state register
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            conv_r <= CONV_IDLE;
        end else begin
            conv_r <= conv_nxt;
        end
    end

    // Done pulse only from busy, one cycle long
    assign conv_done_set = (conv_r == CONV_BUSY) & module_power_on_i & all_done;

    // ************************************************************
    // Flag cells
    // ************************************************************
    // Event inputs are single-cycle pulses from the source logic
    always_comb begin
        hw_set = '0;
        hw_set[SRC_EOC] = conv_done_set;
        hw_set[SRC_DET] = detection_evt_i;
        hw_set[SRC_TMR] = module_timer_evt_i;
        hw_set[SRC_CNT] = conv_counter_evt_i;
        hw_set[SRC_MAX] = max_count_evt_i;
    end

    // Written value per source; reserved bits never reach a cell
    assign wr_bits = tsif_unpack(wdata_i & IMPL_MASK);

    // Only the done flag has hardware clears
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_flag
        tsif_flag_cell u_cell (
            .mclk_i(mclk_i),
            .sys_rst_i(sys_rst_i),
            .kill_i((g == SRC_EOC) ? ~module_power_on_i : 1'b0),
            .set_i(hw_set[g]),
            .clr_i((g == SRC_EOC) ? launch : 1'b0),
            .wr_i(flags_wr),
            .wdata_i(wr_bits[g]),
            .flag_o(flags[g])
        );
    end

    assign touch_irq_flags = tsif_pack(flags);

    // ************************************************************
    // Read path
    // ************************************************************
    // Data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rdata_r <= 16'h0000;
        end else if (!rd_i) begin
            rdata_r <= 16'h0000;
        end else if (tsif_hit(addr_i, ENABLE_OFF)) begin
            rdata_r <= touch_irq_enable_r & IMPL_MASK;
        end else if (tsif_hit(addr_i, FLAGS_OFF)) begin
            rdata_r <= touch_irq_flags & IMPL_MASK;
        end else begin
            // Unmapped addresses answer zero
            rdata_r <= 16'h0000;
        end
    end

    assign rdata_o = rdata_r;
    assign conv_state_o = conv_r;

    // ************************************************************
    // Interrupt request
    // ************************************************************
    // Level request; software must clear the done flag in its
    // handler, else the request stays up after return
    assign irq_o = |(touch_irq_flags & touch_irq_enable_r);

    // ************************************************************
    // Checks
    // ************************************************************
    a_rsvd_read_zero: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        rd_i |=> (rdata_o & ~IMPL_MASK) == 16'h0000)
        else $error("Reserved bits read nonzero");

    a_en_max_store: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        enable_wr |=> touch_irq_enable_r[BIT_MAX] == $past(wdata_i[BIT_MAX]))
        else $error("Max count enable not stored");

    a_en_cnt_hold: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        !enable_wr |=> $stable(touch_irq_enable_r[BIT_CNT]))
        else $error("Counter enable changed without write");

    a_en_tmr_store: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (enable_wr && wdata_i[BIT_TMR]) ##1 !enable_wr [*2]
        |-> touch_irq_enable_r[BIT_TMR])
        else $error("Timer enable lost");

    a_en_det_readback: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (rd_i && tsif_hit(addr_i, ENABLE_OFF))
        |=> rdata_o[BIT_DET] == $past(touch_irq_enable_r[BIT_DET]))
        else $error("Detection enable readback wrong");

    a_en_eoc_store: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        enable_wr |=> touch_irq_enable_r[BIT_EOC] == $past(wdata_i[BIT_EOC]))
        else $error("Done enable not stored");

    a_eoc_irq_level: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (touch_irq_flags[BIT_EOC] && touch_irq_enable_r[BIT_EOC]) |-> irq_o)
        else $error("Done flag enabled but no request");

    a_max_flag_set: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        max_count_evt_i |=> touch_irq_flags[BIT_MAX])
        else $error("Max count flag not set");

    a_cnt_flag_set: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        conv_counter_evt_i |=> touch_irq_flags[BIT_CNT])
        else $error("Counter flag not set");

    a_tmr_flag_set: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        module_timer_evt_i |=> touch_irq_flags[BIT_TMR])
        else $error("Timer flag not set");

    a_det_flag_set: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        detection_evt_i |=> touch_irq_flags[BIT_DET])
        else $error("Detection flag not set");

    a_eoc_set_cause: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        $rose(touch_irq_flags[BIT_EOC])
        |-> $past(conv_done_set) || $past(flags_wr && wdata_i[BIT_EOC]))
        else $error("Done flag set without cause");

    a_eoc_done_sets: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (conv_r == CONV_BUSY && module_power_on_i && all_done)
        |=> touch_irq_flags[BIT_EOC] && conv_r == CONV_DONE)
        else $error("Finished conversion did not set done flag");

    a_eoc_power_clr: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        !module_power_on_i |=> !touch_irq_flags[BIT_EOC])
        else $error("Done flag survived power-off");

    a_eoc_launch_clr: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (launch && !conv_done_set && !flags_wr) |=> !touch_irq_flags[BIT_EOC])
        else $error("Done flag survived launch");

    a_eoc_irq_edge: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        ($rose(touch_irq_flags[BIT_EOC]) && touch_irq_enable_r[BIT_EOC]) |-> irq_o)
        else $error("Done flag edge raised no request");

    a_irq_or_and: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        irq_o == (|(tsif_unpack(touch_irq_flags) & tsif_unpack(touch_irq_enable_r))))
        else $error("Request does not match flags and enables");

    a_flag_write: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (flags_wr && !detection_evt_i) |=> touch_irq_flags[BIT_DET] == $past(wdata_i[BIT_DET]))
        else $error("Flag write not stored");

endmodule

/* tsif_ctrl_tb.sv */
// Self-checking testbench of the touch interrupt enable and flag block
module tsif_ctrl_tb
    import tsif_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk; // System clock
    logic sys_rst; // Synchronous reset
    logic [15:0] addr; // Bus address from the model
    logic [15:0] wdata; // Bus write data from the model
    logic wr; // Write strobe
    logic rd; // Read strobe
    logic [15:0] rdata; // Read data
    logic [3:0] evt; // Events: detection, timer, counter, max count
    logic [15:0] ch_en; // Taking part receive channels
    logic [15:0] ch_done; // Per-channel result ready
    logic cip; // Conversion running
    logic pwr; // Module power control
    logic [1:0] conv_state; // Tracker state
    logic irq; // Interrupt request
    logic [15:0] seen; // Value read back
    int err_count; // Mismatches
    int checks_done; // Comparisons made
    logic [15:0] bitv [4] = '{16'h0002, 16'h0004, 16'h0008, 16'h0100}; // Flag bit per event

    tsif_ctrl #(.NUM_CH(16)) tsif_ctrl_i (.mclk_i(mclk), .sys_rst_i(sys_rst), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .max_count_evt_i(evt[3]),
        .conv_counter_evt_i(evt[2]), .module_timer_evt_i(evt[1]), .detection_evt_i(evt[0]),
        .receive_channel_en_i(ch_en), .receive_channel_done_i(ch_done),
        .conversion_in_progress_i(cip), .module_power_on_i(pwr), .conv_state_o(conv_state),
        .irq_o(irq));

    tsif_cpu_model tsif_cpu_model_i (.mclk_i(mclk), .rdata_i(rdata), .irq_i(irq),
        .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

    // ************************************************************
    // Clock and watchdog
    // ************************************************************
    always #5 mclk = ~mclk;

    // Whole run is about a hundred cycles; this margin only catches a hang
    initial begin
        #20000;
        err_count++;
        stop_test();
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    // Compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Register read compared against an expectation
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        tsif_cpu_model_i.bus_read(a, seen);
        check(seen, exp);
    endtask

    // Register write
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        tsif_cpu_model_i.bus_write(a, d);
    endtask

    // Interrupt level, looked at once settled
    task automatic irq_chk(input logic exp);
        #1;
        check({15'h0000, irq}, {15'h0000, exp});
    endtask

    // One-cycle event pulse
    task automatic pulse(input int k);
        @(posedge mclk);
        evt[k] <= 1'b1;
        @(posedge mclk);
        evt <= 4'h0;
    endtask

    // Falling then rising conversion indicator; tracker busy one edge after the rise
    task automatic launch();
        @(posedge mclk);
        cip <= 1'b0;
        @(posedge mclk);
        cip <= 1'b1;
        @(posedge mclk);
        #1;
        check({14'h0000, conv_state}, {14'h0000, CONV_BUSY});
    endtask

    // Verdict, reached from the main sequence or the watchdog
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        evt = 4'h0;
        ch_en = 16'h0005;
        ch_done = 16'h0000;
        cip = 1'b0;
        pwr = 1'b1;
        err_count = 0;
        checks_done = 0;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        // Reset values and reserved bits
        rd_chk(ENABLE_OFF, 16'h0000);
        rd_chk(FLAGS_OFF, 16'h0000);
        irq_chk(1'b0);
        wr_reg(ENABLE_OFF, 16'hFFFF);
        rd_chk(ENABLE_OFF, 16'h010F);
        wr_reg(FLAGS_OFF, 16'hFFFF);
        rd_chk(FLAGS_OFF, 16'h010F);
        irq_chk(1'b1);
        wr_reg(FLAGS_OFF, 16'h0000);
        irq_chk(1'b0);
        // Unmapped place: write lost, read zero
        wr_reg(16'h0124, 16'hFFFF);
        rd_chk(16'h0124, 16'h0000);
        rd_chk(ENABLE_OFF, 16'h010F);
        wr_reg(ENABLE_OFF, 16'h0000);
        // Each event: flag sets, masked until enabled, cleared by writing zero
        for (int k = 0; k < 4; k++) begin
            pulse(k);
            rd_chk(FLAGS_OFF, bitv[k]);
            irq_chk(1'b0);
            wr_reg(ENABLE_OFF, bitv[k]);
            irq_chk(1'b1);
            wr_reg(FLAGS_OFF, 16'h0000);
            irq_chk(1'b0);
        end
        // Conversion: partial completion must not set the done flag
        wr_reg(ENABLE_OFF, 16'h0001);
        launch();
        @(posedge mclk);
        ch_done <= 16'h0001;
        repeat (3) @(posedge mclk);
        rd_chk(FLAGS_OFF, 16'h0000);
        irq_chk(1'b0);
        // All taking-part channels ready: flag and request one edge later
        @(posedge mclk);
        ch_done <= 16'h0005;
        @(posedge mclk);
        irq_chk(1'b1);
        check({14'h0000, conv_state}, {14'h0000, CONV_DONE});
        rd_chk(FLAGS_OFF, 16'h0001);
        tsif_cpu_model_i.service_conv_done(seen);
        irq_chk(1'b0);
        // New launch clears a pending done flag
        @(posedge mclk);
        ch_done <= 16'h0000;
        wr_reg(FLAGS_OFF, 16'h0001);
        launch();
        rd_chk(FLAGS_OFF, 16'h0000);
        // Power off clears it too
        wr_reg(FLAGS_OFF, 16'h0001);
        @(posedge mclk);
        pwr <= 1'b0;
        repeat (2) @(posedge mclk);
        rd_chk(FLAGS_OFF, 16'h0000);
        pwr <= 1'b1;
        stop_test();
    end
endmodule

/* tsif_flag_cell.sv */
// One sticky interrupt flag with hardware set, hardware clears and software write
module tsif_flag_cell
    import tsif_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic kill_i,
    input wire logic set_i,
    input wire logic clr_i,
    input wire logic wr_i,
    input wire logic wdata_i,
    output logic flag_o
);

    logic flag_r;    // Stored flag
    logic flag_nxt;  // Next flag value

    // ************************************************************
    // Priority: forced clear, then set, then write, then soft clear
    // ************************************************************
    always_comb begin
        flag_nxt = flag_r;
        if (kill_i) begin
            // Power-off wipes the flag whatever else happens
            flag_nxt = 1'b0;
        end else if (set_i) begin
            // An event never gets lost to a same-cycle write
            flag_nxt = 1'b1;
        end else if (wr_i) begin
            // Software stores the written value
            flag_nxt = wdata_i;
        end else if (clr_i) begin
            flag_nxt = 1'b0;
        end
    end

    // Flag register
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag_o = flag_r;

endmodule

/* tsif_pkg.sv */
// Constants, types and helpers shared by the touch interrupt enable and flag block
// Overview of operation
// - Unused bits ignore writes, always read zero
// - Enable bit 8: max count interrupt
// - Enable bit 3: conversion counter interrupt
// - Enable bit 2: module timer interrupt
// - Enable bit 1: detection interrupt
// - Enable bit 0: conversion done interrupt
// - Done flag with enable requests interrupt
// - Flag bit 8: maximum count reached
// - Flag bit 3: conversion count reached
// - Flag bit 2: module timer pending
// - Flag bit 1: detection pending
// - Done flag set when enabled channels finish
// - Done flag cleared on launch or power-off
// - Done flag rising edge raises interrupt
package tsif_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int unsigned ADDR_W = 16;  // Register address width
    localparam int unsigned DATA_W = 16;  // Register data width
    localparam int unsigned NUM_SRC = 5;  // Interrupt sources

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [15:0] ENABLE_OFF = 16'h0120;  // touch_irq_enable
    localparam logic [15:0] FLAGS_OFF = 16'h0122;   // touch_irq_flags
    localparam logic [15:0] ENABLE_RST = 16'h0000;  // Enable reset value
    localparam logic [15:0] FLAGS_RST = 16'h0000;   // Flag reset value
    localparam logic [15:0] IMPL_MASK = 16'h010F;   // Implemented bits

    // ************************************************************
    // Source index inside the packed five-bit vectors
    // ************************************************************
    localparam int unsigned SRC_EOC = 0;  // Conversion done
    localparam int unsigned SRC_DET = 1;  // Detection
    localparam int unsigned SRC_TMR = 2;  // Module timer
    localparam int unsigned SRC_CNT = 3;  // Conversion counter
    localparam int unsigned SRC_MAX = 4;  // Maximum count

    // Register bit positions of the fields
    localparam int unsigned BIT_EOC = 0;
    localparam int unsigned BIT_DET = 1;
    localparam int unsigned BIT_TMR = 2;
    localparam int unsigned BIT_CNT = 3;
    localparam int unsigned BIT_MAX = 8;

    // Conversion tracker states, Gray along idle-busy-done
    typedef enum logic [1:0] {
        CONV_IDLE = 2'h0,
        CONV_BUSY = 2'h1,
        CONV_DONE = 2'h3
    } tsif_conv_t;

    // Spread five source bits onto register positions
    function automatic logic [15:0] tsif_pack(input logic [4:0] v);
        return {7'h00, v[4], 4'h0, v[3:0]};
    endfunction

    // Gather register positions into five source bits
    function automatic logic [4:0] tsif_unpack(input logic [15:0] w);
        return {w[BIT_MAX], w[BIT_CNT:BIT_EOC]};
    endfunction

endpackage
